//--- src/tlpv_pkg.sv
// Package of constants shared by both ends of the tri-level pull value link.
// Assumes one 200 MHz clock on each end and inputs synchronous to it.
//
// Overview of operation
// [R01] Low word to 0x07 first, stored only.
// [R02] High word to 0x06 applies combined value.
// [R03] Frame is header 0xFA0A, address, data.
// [R04] Host splits 23 bits: upper sixteen, lowest seven.
// [R05] Pull value is 23-bit two's complement, signed.
// [R06] High phase then mid phase is one.
// [R07] Low phase then mid phase is zero.
// [R08] Line rests at mid between bits, idle.
// [R09] Bit period is driven plus mid phase.
// [R10] Host releases line for mid level.
// [R11] Mid phase long enough for settling.
// [R12] Extra enable cycle keeps data, enable apart.
// [R13] Frame is exactly 40 bits.
// [R14] Most significant bit sent first.
// [R15] At least 2 us between frames.
// [R16] Reset clears both registers to zero.
// [R17] Frame with wrong header is discarded.
package tlpv_pkg;

	localparam logic [15:0] TLPV_HEADER     = 16'hFA0A;
	localparam logic [7:0]  TLPV_ADDR_HIGH  = 8'h06;
	localparam logic [7:0]  TLPV_ADDR_LOW   = 8'h07;
	localparam int          TLPV_FRAME_BITS = 40;
	localparam int          TLPV_HDR_MSB    = 39;
	localparam int          TLPV_HDR_LSB    = 24;
	localparam int          TLPV_ADDR_MSB   = 23;
	localparam int          TLPV_ADDR_LSB   = 16;
	localparam int          TLPV_DATA_MSB   = 15;
	localparam int          TLPV_LOW_BITS   = 7;
	localparam int          TLPV_PULL_W     = 23;
	localparam int          TLPV_WORD_W     = 24;
	localparam int          TLPV_FIFO_DEPTH = 8;
	localparam logic [15:0] TLPV_WORD_RESET = 16'h0000;
	localparam logic [22:0] TLPV_PULL_RESET = 23'h000000;

	localparam int TLPV_CLK_PERIOD_NS = 5;
	localparam int TLPV_DRIVE_NS      = 100;
	localparam int TLPV_MID_NS        = 200;
	localparam int TLPV_GAP_NS        = 2000;
	localparam int TLPV_RESYNC_NS     = 1000;

	localparam int TLPV_DRIVE_CYC  = (TLPV_DRIVE_NS + TLPV_CLK_PERIOD_NS - 1) / TLPV_CLK_PERIOD_NS;
	localparam int TLPV_MID_CYC    = (TLPV_MID_NS + TLPV_CLK_PERIOD_NS - 1) / TLPV_CLK_PERIOD_NS;
	localparam int TLPV_GAP_CYC    = (TLPV_GAP_NS + TLPV_CLK_PERIOD_NS - 1) / TLPV_CLK_PERIOD_NS;
	localparam int TLPV_RESYNC_CYC = TLPV_RESYNC_NS / TLPV_CLK_PERIOD_NS;

endpackage

//--- src/tlpv_link_if.sv
// Interface joining the host end and the device end over the one control line.
// The host drives a data level and an enable; the line level is worked out here.
`timescale 1ns/100ps
interface tlpv_link_if;
	logic drv_data;
	logic drv_en;
	logic line_high;
	logic line_low;

	// Released line sits at mid level through the resistive divider.
	assign line_high = drv_en & drv_data;
	assign line_low  = drv_en & ~drv_data;

	modport host (output drv_data, output drv_en);
	modport dev  (input line_high, input line_low);
endinterface

//--- src/tlpv_device.sv
// Device end: decodes tri-level bits into frames and holds the pull registers.
// Assumes the line levels are synchronous to clk and each phase lasts many cycles.
`timescale 1ns/100ps
module tlpv_device
	import tlpv_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	tlpv_link_if.dev                      link,
	output logic [15:0]                   high_word,
	output logic [15:0]                   low_bits,
	output logic signed [TLPV_PULL_W-1:0] pull_value,
	output logic                          pull_update,
	output logic                          frame_reject
);

	typedef enum logic {TLPV_D_REST, TLPV_D_DRIVEN} tlpv_dphase_t;

	typedef struct packed {
		tlpv_dphase_t phase;
		logic         bit_val;
		logic [39:0]  shift;
		logic [5:0]   nbits;
		logic [7:0]   rest_cnt;
		logic [15:0]  high;
		logic [15:0]  low;
		logic [22:0]  pull;
		logic         upd;
		logic         rej;
	} tlpv_dstate_t;

	tlpv_dstate_t state_reg;
	tlpv_dstate_t state_next;
	logic [39:0]  frame;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_next     = state_reg;
		state_next.upd = 1'b0;
		state_next.rej = 1'b0;
		frame          = {state_reg.shift[38:0], state_reg.bit_val}; // [R14]
		if (link.line_high || link.line_low) begin
			state_next.phase    = TLPV_D_DRIVEN;
			state_next.bit_val  = link.line_high; // [R06] [R07]
			state_next.rest_cnt = 8'h00;
		end else if (state_reg.phase == TLPV_D_DRIVEN) begin
			// The return to mid level completes the bit.
			state_next.phase = TLPV_D_REST; // [R08]
			state_next.shift = frame;
			state_next.nbits = state_reg.nbits + 6'h01;
			if (state_reg.nbits == 6'(TLPV_FRAME_BITS - 1)) begin // [R13]
				state_next.nbits = 6'h00;
				if (frame[TLPV_HDR_MSB:TLPV_HDR_LSB] != TLPV_HEADER) begin
					state_next.rej = 1'b1; // [R17]
				end else if (frame[TLPV_ADDR_MSB:TLPV_ADDR_LSB] == TLPV_ADDR_HIGH) begin // [R03]
					state_next.high = frame[TLPV_DATA_MSB:0];
					state_next.pull = {frame[TLPV_DATA_MSB:0], state_reg.low[TLPV_LOW_BITS-1:0]}; // [R02]
					state_next.upd  = 1'b1;
				end else if (frame[TLPV_ADDR_MSB:TLPV_ADDR_LSB] == TLPV_ADDR_LOW) begin
					state_next.low = frame[TLPV_DATA_MSB:0]; // [R01]
				end
			end
		end else if (state_reg.rest_cnt == 8'(TLPV_RESYNC_CYC - 1)) begin
			// A long rest means a frame boundary; a partial frame is dropped.
			state_next.nbits = 6'h00;
		end else begin
			state_next.rest_cnt = state_reg.rest_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg          <= '0;
			state_reg.phase    <= TLPV_D_REST;
			state_reg.high     <= TLPV_WORD_RESET; // [R16]
			state_reg.low      <= TLPV_WORD_RESET; // [R16]
			state_reg.pull     <= TLPV_PULL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign high_word    = state_reg.high;
	assign low_bits     = state_reg.low;
	assign pull_value   = signed'(state_reg.pull); // [R05]
	assign pull_update  = state_reg.upd;
	assign frame_reject = state_reg.rej;

endmodule

//--- src/tlpv_host.sv
// Host end: queues pull value requests and sends them as tri-level frames.
// Holds the word FIFO as a module of its own and the line driver.
// Assumes the device end samples the same line on a clock of similar rate.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////

module tlpv_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} tlpv_fstate_t;

	tlpv_fstate_t state_reg;
	tlpv_fstate_t state_next;
	logic         push;
	logic         pop;

	assign in_ready  = (state_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (state_reg.cnt != '0);
	assign out_data  = state_reg.mem[state_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wp] = in_data;
			state_next.wp = (state_reg.wp == AW'(DEPTH - 1)) ? '0 : state_reg.wp + 1'b1;
		end
		if (pop) begin
			state_next.rp = (state_reg.rp == AW'(DEPTH - 1)) ? '0 : state_reg.rp + 1'b1;
		end
		if (push && !pop) begin
			state_next.cnt = state_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			state_next.cnt = state_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

////////////////////////////////////////////////////////////////////////////////

module tlpv_host
	import tlpv_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic [TLPV_PULL_W-1:0]  req_value,
	input  wire logic                    req_hires,
	input  wire logic                    req_valid,
	output logic                         req_ready,
	output logic                         busy,
	tlpv_link_if.host                    link
);

	typedef enum logic [2:0] {
		TLPV_H_IDLE,
		TLPV_H_SETUP,
		TLPV_H_DRIVE,
		TLPV_H_MID,
		TLPV_H_GAP
	} tlpv_hphase_t;

	typedef struct packed {
		tlpv_hphase_t st;
		logic [39:0]  shift;
		logic [5:0]   nbit;
		logic [8:0]   tmr;
		logic         data;
		logic         en;
		logic         pend;
		logic [23:0]  pend_word;
	} tlpv_hstate_t;

	tlpv_hstate_t             state_reg;
	tlpv_hstate_t             state_next;
	logic [TLPV_WORD_W-1:0]   fifo_in;
	logic                     fifo_in_valid;
	logic                     fifo_in_ready;
	logic [TLPV_WORD_W-1:0]   fifo_out;
	logic                     fifo_out_valid;
	logic                     fifo_out_ready;
	logic [TLPV_WORD_W-1:0]   low_word;
	logic [TLPV_WORD_W-1:0]   high_word;

	////////////////////////////////////////////////////////////////////////////////
	// Request loader: a high resolution request becomes two queued words.

	assign low_word  = {TLPV_ADDR_LOW, 9'h000, req_value[TLPV_LOW_BITS-1:0]}; // [R04]
	assign high_word = {TLPV_ADDR_HIGH, req_value[TLPV_PULL_W-1:TLPV_LOW_BITS]}; // [R04] [R05]

	assign req_ready     = !state_reg.pend && fifo_in_ready;
	assign fifo_in_valid = state_reg.pend || req_valid;
	assign fifo_in       = state_reg.pend ? state_reg.pend_word
	                     : (req_hires ? low_word : high_word); // [R01]

	tlpv_fifo #(
		.WIDTH (TLPV_WORD_W),
		.DEPTH (TLPV_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_data   (fifo_in),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready)
	);

	// Words are taken only between frames, so the gap is always kept.
	assign fifo_out_ready = (state_reg.st == TLPV_H_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// Serialiser.

	always_comb begin
		state_next = state_reg;
		if (state_reg.pend && fifo_in_ready) begin
			state_next.pend = 1'b0;
		end else if (req_valid && req_ready && req_hires) begin
			// The high word follows the low word as the next queued entry.
			state_next.pend      = 1'b1; // [R02]
			state_next.pend_word = high_word;
		end
		case (state_reg.st)
			TLPV_H_IDLE: begin
				if (fifo_out_valid) begin
					state_next.shift = {TLPV_HEADER, fifo_out}; // [R03]
					state_next.nbit  = 6'h00;
					state_next.data  = TLPV_HEADER[15]; // [R14]
					state_next.st    = TLPV_H_SETUP;
				end
			end
			TLPV_H_SETUP: begin
				// Data settled for a cycle before the enable rises.
				state_next.en  = 1'b1; // [R12]
				state_next.tmr = 9'h000;
				state_next.st  = TLPV_H_DRIVE;
			end
			TLPV_H_DRIVE: begin
				if (state_reg.tmr == 9'(TLPV_DRIVE_CYC - 1)) begin
					state_next.en  = 1'b0; // [R10] [R08]
					state_next.tmr = 9'h000;
					state_next.st  = TLPV_H_MID;
				end else begin
					state_next.tmr = state_reg.tmr + 9'h001;
				end
			end
			TLPV_H_MID: begin
				if (state_reg.tmr != 9'(TLPV_MID_CYC - 1)) begin // [R11] [R09]
					state_next.tmr = state_reg.tmr + 9'h001;
				end else if (state_reg.nbit == 6'(TLPV_FRAME_BITS - 1)) begin // [R13]
					state_next.tmr = 9'h000;
					state_next.st  = TLPV_H_GAP;
				end else begin
					state_next.shift = {state_reg.shift[38:0], 1'b0}; // [R14]
					state_next.data  = state_reg.shift[38]; // [R06] [R07]
					state_next.nbit  = state_reg.nbit + 6'h01;
					state_next.st    = TLPV_H_SETUP;
				end
			end
			TLPV_H_GAP: begin
				if (state_reg.tmr == 9'(TLPV_GAP_CYC - 1)) begin // [R15]
					state_next.st = TLPV_H_IDLE;
				end else begin
					state_next.tmr = state_reg.tmr + 9'h001;
				end
			end
			default: begin
				state_next.st = TLPV_H_IDLE;
				state_next.en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= '0;
			state_reg.st <= TLPV_H_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.drv_data = state_reg.data;
	assign link.drv_en   = state_reg.en;
	assign busy          = (state_reg.st != TLPV_H_IDLE) || fifo_out_valid || state_reg.pend;

endmodule

//--- sim/tlpv_checker.sv
// Checker of the host drive on the link between the two ends.
// Assumes one clock and the line signals of the link interface.
`timescale 1ns/100ps
module tlpv_checker
	import tlpv_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic drv_data,
	input wire logic drv_en,
	input wire logic line_high,
	input wire logic line_low
);
	logic [11:0] run_reg;
	logic [11:0] mid_reg;
	logic [5:0]  bit_reg;
	logic        en_reg;

	// The mid count starts saturated so the first bit after reset meets the frame gap check.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_reg <= 12'h000;
			mid_reg <= 12'hFFF;
			bit_reg <= 6'h00;
			en_reg  <= 1'b0;
		end else begin
			run_reg <= drv_en ? run_reg + 12'h001 : 12'h000;
			mid_reg <= drv_en ? 12'h000 : (mid_reg == 12'hFFF ? mid_reg : mid_reg + 12'h001);
			en_reg  <= drv_en;
			if (drv_en && !en_reg)
				bit_reg <= (bit_reg == 6'(TLPV_FRAME_BITS - 1)) ? 6'h00 : bit_reg + 6'h01;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_bit_start;
		$rose(drv_en);
	endsequence
	sequence s_inner_bit;
		$rose(drv_en) && bit_reg != 6'h00;
	endsequence
	sequence s_frame_start;
		$rose(drv_en) && bit_reg == 6'h00;
	endsequence
	sequence s_header_bit;
		$rose(drv_en) && bit_reg < 6'h10;
	endsequence
	sequence s_addr_bit;
		$rose(drv_en) && bit_reg >= 6'h10 && bit_reg < 6'h17;
	endsequence

	a_drive_steady: assert property (drv_en |-> $stable(drv_data))
		else $error("data moved while driven");
	a_drive_length: assert property ($fell(drv_en) |-> run_reg == 12'(TLPV_DRIVE_CYC))
		else $error("drive phase length");
	a_mid_rests: assert property (s_bit_start |-> mid_reg >= 12'(TLPV_MID_CYC + 1))
		else $error("mid phase too short");
	a_inner_spacing: assert property (s_inner_bit |-> mid_reg == 12'(TLPV_MID_CYC + 1))
		else $error("bit spacing");
	a_frame_gap: assert property (s_frame_start |-> mid_reg >= 12'(TLPV_GAP_CYC + TLPV_MID_CYC))
		else $error("frame gap too short");
	a_header_bits: assert property (s_header_bit |-> drv_data == TLPV_HEADER[5'h0F - bit_reg[4:0]])
		else $error("header bit wrong");
	a_addr_bits: assert property (s_addr_bit |-> drv_data == (bit_reg == 6'h15 || bit_reg == 6'h16))
		else $error("address bit wrong");
	a_line_levels: assert property (drv_en ? (line_high == drv_data && line_low == !drv_data)
		: !(line_high || line_low))
		else $error("line level wrong");
endmodule

//--- sim/trilevel_pull_value_writer_tb.sv
// Testbench joining host and device ends, plus a device fed by a raw line driver.
// Assumes the package constants and a 200 MHz clock.
`timescale 1ns/100ps
module trilevel_pull_value_writer_tb
	import tlpv_pkg::*;
;
	logic               clk;
	logic               arst_n;
	logic               req_hires;
	logic               req_valid;
	logic               req_ready;
	logic               busy;
	logic               pull_update;
	logic               reject_raw;
	logic [22:0]        req_value;
	logic [15:0]        high_word;
	logic [15:0]        low_bits;
	logic [15:0]        high_word_raw;
	logic signed [22:0] pull_value;
	int                 bad_count;
	int                 total_checks;
	int                 upd_count;
	int                 rej_count;
	int                 cycles;

	tlpv_link_if i_tlpv_link_if ();
	tlpv_link_if i_raw_link_if ();
	tlpv_host i_tlpv_host (.clk(clk), .arst_n(arst_n), .req_value(req_value), .req_hires(req_hires),
		.req_valid(req_valid), .req_ready(req_ready), .busy(busy), .link(i_tlpv_link_if.host));
	tlpv_device i_tlpv_device (.clk(clk), .arst_n(arst_n), .link(i_tlpv_link_if.dev), .high_word(high_word),
		.low_bits(low_bits), .pull_value(pull_value), .pull_update(pull_update), .frame_reject());
	tlpv_device i_tlpv_device_raw (.clk(clk), .arst_n(arst_n), .link(i_raw_link_if.dev),
		.high_word(high_word_raw), .low_bits(), .pull_value(), .pull_update(), .frame_reject(reject_raw));
	tlpv_checker i_tlpv_checker (.clk(clk), .arst_n(arst_n), .drv_data(i_tlpv_link_if.drv_data),
		.drv_en(i_tlpv_link_if.drv_en), .line_high(i_tlpv_link_if.line_high), .line_low(i_tlpv_link_if.line_low));

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (pull_update === 1'b1)
			upd_count++;
		if (reject_raw === 1'b1)
			rej_count++;
		if (cycles == 60000) begin
			bad_count++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic send(input logic [22:0] v, input logic h);
		@(posedge clk);
		req_value <= v;
		req_hires <= h;
		req_valid <= 1'b1;
		for (int n = 0; n < 9000; n++) begin
			#1;
			if (req_ready === 1'b1)
				break;
			@(posedge clk);
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask

	task automatic wait_upd(input int target);
		for (int n = 0; n < 30000 && upd_count < target; n++)
			@(posedge clk);
		#1;
	endtask

	task automatic t_hires(input logic [22:0] v, input logic [22:0] prev);
		int base;
		base = upd_count;
		send(v, 1'b1);
		for (int n = 0; n < 4000 && low_bits !== {9'h000, v[6:0]}; n++)
			@(posedge clk);
		#1;
		check("low_bits", low_bits, {9'h000, v[6:0]});
		check("no update", upd_count, base);
		check("held", pull_value[22:0], prev);
		wait_upd(base + 1);
		check("high_word", high_word, v[22:7]);
		check("pull_value", pull_value[22:0], v);
		$display("t_hires %h done", v);
	endtask

	task automatic t_mode1();
		wait_upd(upd_count + 0);
		send(23'h7FFF80, 1'b0);
		wait_upd(upd_count + 1);
		check("high_word", high_word, 16'hFFFF);
		check("pull_value", pull_value[22:0], 23'h7FFF8B);
		check("sign", pull_value < 0, 1'b1);
		$display("t_mode1 done");
	endtask

	task automatic t_fifo();
		int   acc;
		int   base;
		logic rdy;
		acc = 0;
		// Start from an idle host so that one word leaves the queue before it fills.
		for (int n = 0; n < 1000 && busy !== 1'b0; n++)
			@(posedge clk);
		base = upd_count;
		@(posedge clk);
		req_hires <= 1'b0;
		req_value <= {16'hA000, 7'h00};
		req_valid <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			#1;
			rdy = req_ready;
			@(posedge clk);
			if (rdy === 1'b1) begin
				acc++;
				req_value <= {16'hA000 + acc[15:0], 7'h00};
			end
		end
		req_valid <= 1'b0;
		#1;
		check("accepted", acc, 9);
		check("busy", busy, 1'b1);
		wait_upd(base + 9);
		check("updates", upd_count - base, 9);
		check("high_word", high_word, 16'hA008);
		for (int n = 0; n < 1000 && busy !== 1'b0; n++)
			@(posedge clk);
		#1;
		check("idle", busy, 1'b0);
		$display("t_fifo done");
	endtask

	task automatic raw_frame(input logic [39:0] f, input int nb);
		for (int i = 39; i >= 40 - nb; i--) begin
			@(posedge clk);
			i_raw_link_if.drv_data <= f[i];
			@(posedge clk);
			i_raw_link_if.drv_en <= 1'b1;
			repeat (20) @(posedge clk);
			i_raw_link_if.drv_en <= 1'b0;
			repeat (39) @(posedge clk);
		end
		repeat (400) @(posedge clk);
	endtask

	task automatic t_reject();
		raw_frame({16'hFA0B, 8'h06, 16'h1234}, 40);
		check("rejects", rej_count, 1);
		check("kept", high_word_raw, 16'h0000);
		// A cut frame and a long rest must not shift the bits of the next frame.
		raw_frame({16'hFA0A, 8'h06, 16'h0000}, 5);
		raw_frame({16'hFA0A, 8'h06, 16'h1234}, 40);
		check("raw word", high_word_raw, 16'h1234);
		check("no reject", rej_count, 1);
		$display("t_reject done");
	endtask

	task automatic t_reset();
		check("reset word", high_word, TLPV_WORD_RESET);
		check("reset low", low_bits, TLPV_WORD_RESET);
		check("reset pull", pull_value[22:0], TLPV_PULL_RESET);
		$display("t_reset done");
	endtask

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		req_value = 23'h000000;
		req_hires = 1'b0;
		req_valid = 1'b0;
		i_raw_link_if.drv_data = 1'b0;
		i_raw_link_if.drv_en = 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		t_reset();
		t_hires(23'h09CF8A, 23'h000000);
		t_hires(23'h5ECC0B, 23'h09CF8A);
		t_mode1();
		t_fifo();
		t_reject();
		end_of_test();
	end
endmodule
